// File: rtl/config_startup_sequencer.sv
// Startup sequencer with AHB-Lite settings registers
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer import startup_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Status inputs
	input wire logic clocks_locked,
	input wire logic calib_matched,
	// Startup outputs
	output logic completion,
	output logic global_io_tristate,
	output logic global_write_enable,
	output logic block_ram_enable,
	output logic global_interconnect_hold,
	output logic global_set_reset,
	// Configuration access
	output logic upper_port_enable,
	output logic lower_port_enable,
	output logic readback_allowed,
	output logic reconfig_allowed
);

	////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] ctl;
	logic [31:0] phases;
	logic start_pulse;
	logic addr_ok;
	startup_cfg_t cfg;
	startup_out_t outs;
	security_t sec_level;
	port_sel_t port_sel;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	logic running;
	logic [3:0] phase;
	logic done_seen;
	logic sec_lock;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl <= 32'h0000_0000;
			phases <= {12'h000, MATCH_PHASE_RST, LOCK_PHASE_RST,
				WRITE_PHASE_RST, TRISTATE_PHASE_RST, DONE_PHASE_RST};
			start_pulse <= 1'b0;
		end else begin
			start_pulse <= 1'b0;
			// Settings frozen once level two is armed
			if (wr_pend && !sec_lock && wr_addr == OFF_CONTROL) begin
				ctl <= hwdata;
				start_pulse <= hwdata[CTL_START];
			end
			if (wr_pend && !sec_lock && !running && wr_addr == OFF_PHASES) begin
				phases <= hwdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				OFF_CONTROL: hrdata <= ctl;
				OFF_PHASES: hrdata <= phases;
				OFF_STATUS: hrdata <= {20'h00000, phase, done_seen,
					running, outs};
				OFF_ACCESS: hrdata <= {30'h0, reconfig_allowed,
					readback_allowed};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		cfg.done_phase = phases[PH_DONE +: 4];
		cfg.tristate_phase = phases[PH_TRI +: 4];
		cfg.write_phase = phases[PH_WRITE +: 4];
		cfg.lock_phase = phases[PH_LOCK +: 4];
		cfg.match_phase = phases[PH_MATCH +: 4];
		cfg.pipe_done = ctl[CTL_PIPE];
		cfg.active_reconfiguration = ctl[CTL_ACTIVE];
		cfg.calib_io_used = ctl[CTL_CALIB_IO];
		sec_level = security_t'(ctl[CTL_SEC_LO +: 2]);
		port_sel = port_sel_t'(ctl[CTL_PORT_LO +: 2]);
	end
	assign sec_lock = (sec_level == SEC_TWO);

	////////////////////////////////////////////////////////////////////////
	// Security and port selection
	security_gate u_sec (
		.hclk(hclk),
		.hresetn(hresetn),
		.level(sec_level),
		.readback_ok(readback_allowed),
		.reconfig_ok(reconfig_allowed)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			upper_port_enable <= 1'b1;
			lower_port_enable <= 1'b0;
		end else begin
			// Automatic picks the upper port
			upper_port_enable <= (port_sel != PORT_LOWER);
			lower_port_enable <= (port_sel == PORT_LOWER);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase counter
	logic [3:0] eff_match;
	logic lock_stall;
	logic match_stall;
	logic stall;
	logic last_phase;
	logic done_raw;
	logic done_now;

	always_comb begin
		if (cfg.match_phase == CHOICE_AUTO) begin
			eff_match = cfg.calib_io_used ? AUTO_MATCH_PHASE
				: CHOICE_NO_WAIT;
		end else begin
			eff_match = cfg.match_phase;
		end
	end

	// Wait phases only look at status; calibration runs on its own
	assign lock_stall = running && (cfg.lock_phase <= PHASE_MAX)
		&& phase == cfg.lock_phase && !clocks_locked;
	assign match_stall = running && (eff_match <= PHASE_MAX)
		&& phase == eff_match && !calib_matched;
	assign stall = lock_stall || match_stall;
	assign last_phase = (phase == PHASE_MAX);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			running <= 1'b0;
			phase <= 4'h0;
		end else if (start_pulse && !running && reconfig_allowed) begin
			running <= 1'b1;
			phase <= 4'h0;
		end else if (running && !stall) begin
			if (last_phase) begin
				running <= 1'b0;
			end else begin
				phase <= phase + 4'h1;
			end
		end
	end

	phase_hit u_done (
		.choice(cfg.done_phase),
		.phase(phase),
		.running(running && !stall),
		.done_now(1'b0),
		.hit(done_raw)
	);

	////////////////////////////////////////////////////////////////////////
	// Completion and global controls
	logic done_pipe;
	logic tri_hit;
	logic we_hit;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_pipe <= 1'b0;
		end else begin
			done_pipe <= done_raw;
		end
	end
	assign done_now = cfg.pipe_done ? done_pipe : done_raw;

	phase_hit u_tri (
		.choice(cfg.tristate_phase),
		.phase(phase),
		.running(running && !stall),
		.done_now(done_now),
		.hit(tri_hit)
	);

	phase_hit u_we (
		.choice(cfg.write_phase),
		.phase(phase),
		.running(running && !stall),
		.done_now(done_now),
		.hit(we_hit)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_seen <= 1'b0;
			outs <= '{completion: 1'b0, global_io_tristate: 1'b1,
				global_write_enable: 1'b0, block_ram_enable: 1'b0,
				global_interconnect_hold: 1'b1, global_set_reset: 1'b1};
		end else begin
			// Keep choices never hit, so outputs stay put
			if (done_now) begin
				outs.completion <= 1'b1;
				done_seen <= 1'b1;
			end
			if (tri_hit) begin
				outs.global_io_tristate <= 1'b0;
			end
			if (we_hit) begin
				outs.global_write_enable <= 1'b1;
				outs.block_ram_enable <= 1'b1;
			end
			if (start_pulse && !running && reconfig_allowed) begin
				outs.global_interconnect_hold <= !cfg.active_reconfiguration;
				outs.global_set_reset <= !cfg.active_reconfiguration;
			end else if (cfg.active_reconfiguration) begin
				outs.global_interconnect_hold <= 1'b0;
				outs.global_set_reset <= 1'b0;
			end else if (we_hit) begin
				outs.global_interconnect_hold <= 1'b0;
				outs.global_set_reset <= 1'b0;
			end
		end
	end

	assign completion = outs.completion;
	assign global_io_tristate = outs.global_io_tristate;
	assign global_write_enable = outs.global_write_enable;
	assign block_ram_enable = outs.block_ram_enable;
	assign global_interconnect_hold = outs.global_interconnect_hold;
	assign global_set_reset = outs.global_set_reset;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_ram_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
		block_ram_enable |-> global_write_enable)
		else $error("block ram enabled before write enable");
	a_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		lock_stall |=> $stable(phase) && running)
		else $error("phase moved while waiting for lock");
	a_match_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		match_stall |=> $stable(phase))
		else $error("phase moved while waiting for match");
	a_phase_step: assert property (@(posedge hclk) disable iff (!hresetn)
		running && !stall && !last_phase |=> phase == $past(phase) + 4'h1)
		else $error("phase did not advance by one");
	a_active_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg.active_reconfiguration && !start_pulse |=>
		!global_set_reset && !global_interconnect_hold)
		else $error("hold or set/reset during active reconfiguration");
	a_level_one: assert property (@(posedge hclk) disable iff (!hresetn)
		sec_level == SEC_ONE |=> !readback_allowed && reconfig_allowed)
		else $error("level one permissions wrong");
	a_level_two: assert property (@(posedge hclk) disable iff (!hresetn)
		sec_level == SEC_TWO |=> !readback_allowed && !reconfig_allowed)
		else $error("level two permissions wrong");
	a_done_phase: assert property (@(posedge hclk) disable iff (!hresetn)
		done_raw && !cfg.pipe_done |=> completion)
		else $error("completion missed its phase");
	a_done_pipe: assert property (@(posedge hclk) disable iff (!hresetn)
		done_raw && cfg.pipe_done && !completion |=>
		!completion ##1 completion)
		else $error("delayed completion missing");
	a_port_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		port_sel == PORT_LOWER |=> lower_port_enable && !upper_port_enable)
		else $error("lower port not selected");

endmodule : config_startup_sequencer
`default_nettype wire

// File: rtl/startup_pkg.sv
// Constants, choices and carriers for the startup sequencer
package startup_pkg;

	// Phase choice codes (4 bits): 0..6 are phases
	localparam logic [3:0] PHASE_MAX = 4'h6;
	localparam logic [3:0] CHOICE_DONE = 4'h8;
	localparam logic [3:0] CHOICE_KEEP = 4'h9;
	localparam logic [3:0] CHOICE_NO_WAIT = 4'ha;
	localparam logic [3:0] CHOICE_AUTO = 4'hb;

	// Reset values of settings
	localparam logic [3:0] DONE_PHASE_RST = 4'h4;
	localparam logic [3:0] TRISTATE_PHASE_RST = 4'h5;
	localparam logic [3:0] WRITE_PHASE_RST = 4'h6;
	localparam logic [3:0] LOCK_PHASE_RST = CHOICE_NO_WAIT;
	localparam logic [3:0] MATCH_PHASE_RST = CHOICE_AUTO;
	localparam logic [3:0] AUTO_MATCH_PHASE = 4'h2;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PHASES = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_ACCESS = 8'h0c;

	// Control register fields
	localparam int CTL_START = 0;
	localparam int CTL_PIPE = 1;
	localparam int CTL_ACTIVE = 2;
	localparam int CTL_PORT_LO = 4;
	localparam int CTL_SEC_LO = 8;
	localparam int CTL_CALIB_IO = 12;
	// Phase register fields, 4 bits each
	localparam int PH_DONE = 0;
	localparam int PH_TRI = 4;
	localparam int PH_WRITE = 8;
	localparam int PH_LOCK = 12;
	localparam int PH_MATCH = 16;
	// Access register fields
	localparam int ACC_READBACK = 0;
	localparam int ACC_RECONFIG = 1;

	typedef enum logic [1:0] {PORT_AUTO, PORT_UPPER, PORT_LOWER} port_sel_t;
	typedef enum logic [1:0] {SEC_NONE, SEC_ONE, SEC_TWO} security_t;

	typedef struct packed {
		logic [3:0] done_phase;
		logic [3:0] tristate_phase;
		logic [3:0] write_phase;
		logic [3:0] lock_phase;
		logic [3:0] match_phase;
		logic pipe_done;
		logic active_reconfiguration;
		logic calib_io_used;
	} startup_cfg_t;

	typedef struct packed {
		logic completion;
		logic global_io_tristate;
		logic global_write_enable;
		logic block_ram_enable;
		logic global_interconnect_hold;
		logic global_set_reset;
	} startup_out_t;

endpackage : startup_pkg

// File: rtl/phase_hit.sv
// Decides whether a phase choice fires at the current phase
`timescale 1ns/1ps
`default_nettype none
module phase_hit import startup_pkg::*; (
	// Choice and progress
	input wire logic [3:0] choice,
	input wire logic [3:0] phase,
	input wire logic running,
	input wire logic done_now,
	// Result
	output logic hit
);
	always_comb begin
		if (choice == CHOICE_DONE) begin
			hit = done_now;
		end else if (choice <= PHASE_MAX) begin
			hit = running && (phase == choice);
		end else begin
			hit = 1'b0;
		end
	end
endmodule : phase_hit
`default_nettype wire

// File: rtl/security_gate.sv
// Applies the readback and reconfiguration security levels
`timescale 1ns/1ps
`default_nettype none
module security_gate import startup_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Level
	input wire security_t level,
	// Permissions
	output logic readback_ok,
	output logic reconfig_ok
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			readback_ok <= 1'b1;
			reconfig_ok <= 1'b1;
		end else begin
			readback_ok <= (level == SEC_NONE);
			reconfig_ok <= (level != SEC_TWO);
		end
	end
endmodule : security_gate
`default_nettype wire

// File: sim/config_source_model.sv
// Model of the configuration source and its clock managers
`timescale 1ns/1ps
`default_nettype none
module config_source_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bench commands
	input wire logic lock_go,
	input wire logic match_go,
	// Status to the sequencer
	output logic clocks_locked,
	output logic calib_matched
);
	logic [1:0] lock_dly;
	logic [1:0] match_dly;
	// Lock and match report two cycles after go, never started by startup
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_dly <= 2'h0;
			match_dly <= 2'h0;
		end else begin
			lock_dly <= {lock_dly[0], lock_go};
			match_dly <= {match_dly[0], match_go};
		end
	end
	assign clocks_locked = lock_dly[1];
	assign calib_matched = match_dly[1];
endmodule : config_source_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the startup sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import startup_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready, hreadyout, hresp;
	logic [31:0] hrdata, rd;
	logic lock_go = 1'b0;
	logic match_go = 1'b0;
	logic clocks_locked, calib_matched, completion, global_io_tristate;
	logic global_write_enable, block_ram_enable, global_interconnect_hold;
	logic global_set_reset, upper_port_enable, lower_port_enable;
	logic readback_allowed, reconfig_allowed;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int t_done, t_tri, t_we, t_ram, t_gsr, dp, tp, wp, pp, k;
	logic [31:0] seed = 32'h6dc50d0c;

	config_source_model partner (.hclk(hclk), .hresetn(hresetn),
		.lock_go(lock_go), .match_go(match_go),
		.clocks_locked(clocks_locked), .calib_matched(calib_matched));
	config_startup_sequencer dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.clocks_locked(clocks_locked), .calib_matched(calib_matched),
		.completion(completion),
		.global_io_tristate(global_io_tristate),
		.global_write_enable(global_write_enable),
		.block_ram_enable(block_ram_enable),
		.global_interconnect_hold(global_interconnect_hold),
		.global_set_reset(global_set_reset),
		.upper_port_enable(upper_port_enable),
		.lower_port_enable(lower_port_enable),
		.readback_allowed(readback_allowed),
		.reconfig_allowed(reconfig_allowed));
	assign hready = hreadyout;

	////////////////////////////////////////////////////////////////////////
	// Clock runs free, so the sequence always finds edges
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) cyc++;
	always @(posedge completion) t_done = cyc;
	always @(negedge global_io_tristate) t_tri = cyc;
	always @(posedge global_write_enable) t_we = cyc;
	always @(posedge block_ram_enable) t_ram = cyc;
	always @(negedge global_set_reset) t_gsr = cyc;

	////////////////////////////////////////////////////////////////////////
	// Tasks
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			$display("ERROR %0t: %s", $time, msg);
			num_errors++;
		end
	endtask : check

	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		check(hresp === 1'b0, "okay response");
	endtask : bus

	task automatic do_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		lock_go <= 1'b0;
		match_go <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_done = -1;
		t_tri = -1;
		t_we = -1;
		t_ram = -1;
		t_gsr = -1;
	endtask : do_reset

	task automatic launch(input logic [31:0] ctl, input logic [31:0] ph);
		do_reset();
		bus(1'b1, OFF_PHASES, ph);
		bus(1'b1, OFF_CONTROL, ctl | 32'h1);
	endtask : launch

	task automatic wait_done(input logic expect_done);
		for (int n = 0; n < 40 && completion !== 1'b1; n++) @(posedge hclk);
		check(completion === expect_done, "completion level");
		repeat (8) @(posedge hclk);
	endtask : wait_done

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		do_reset();
		check({completion, global_io_tristate, global_write_enable,
			block_ram_enable, global_interconnect_hold, global_set_reset,
			upper_port_enable, lower_port_enable, readback_allowed,
			reconfig_allowed} === 10'b0100111011, "reset outputs");
		bus(1'b0, OFF_PHASES, 32'h0);
		check(rd === 32'h000ba654, "phase defaults");
		bus(1'b0, 8'h10, 32'h0);
		check(rd === 32'h0, "unmapped read");
		for (int i = 0; i < 6; i++) begin
			dp = 1 + xs() % 6;
			tp = (i == 0) ? 8 : 1 + xs() % 6;
			wp = 1 + xs() % 6;
			pp = xs() % 2;
			launch(pp << CTL_PIPE, 32'hba000 | (wp << 8) | (tp << 4) | dp);
			wait_done(1'b1);
			k = t_we - wp;
			check(t_done === k + dp + pp, "completion time");
			check(t_tri === ((tp == 8) ? t_done : k + tp), "tristate time");
			check(t_ram === t_we && t_gsr === t_we, "ram enable time");
		end
		bus(1'b0, OFF_STATUS, 32'h0);
		check(rd[7:0] === 8'hac && rd[11:8] === 4'h6, "status after run");
		launch(32'h0, 32'hba994);
		wait_done(1'b1);
		check(global_io_tristate === 1'b1 && global_write_enable === 1'b0
			&& block_ram_enable === 1'b0, "keep choices");
		launch(32'h0, 32'hba659);
		wait_done(1'b0);
		check(t_tri === t_we - 1, "keep completion");
		launch(32'h0, 32'hb3654);
		wait_done(1'b0);
		lock_go <= 1'b1;
		wait_done(1'b1);
		check(t_we - t_done === 2, "after lock");
		launch(32'h1 << CTL_CALIB_IO, 32'hba654);
		wait_done(1'b0);
		match_go <= 1'b1;
		wait_done(1'b1);
		launch(32'h0, 32'h5a654);
		wait_done(1'b1);
		check(global_write_enable === 1'b0, "match stall");
		match_go <= 1'b1;
		repeat (8) @(posedge hclk);
		check(global_write_enable === 1'b1, "match release");
		launch(32'h1 << CTL_ACTIVE, 32'hba654);
		repeat (2) @(posedge hclk);
		check(global_interconnect_hold === 1'b0 && global_set_reset === 1'b0
			&& global_write_enable === 1'b0, "active early");
		wait_done(1'b1);
		check(global_interconnect_hold === 1'b0 && global_set_reset === 1'b0,
			"active late");
		for (int p = 0; p < 3; p++) begin
			bus(1'b1, OFF_CONTROL, p << CTL_PORT_LO);
			repeat (2) @(posedge hclk);
			check(upper_port_enable === (p != 2)
				&& lower_port_enable === (p == 2), "port select");
		end
		launch(32'h1 << CTL_SEC_LO, 32'hba654);
		wait_done(1'b1);
		bus(1'b0, OFF_ACCESS, 32'h0);
		check(rd === 32'h2 && readback_allowed === 1'b0
			&& reconfig_allowed === 1'b1, "level one");
		do_reset();
		bus(1'b1, OFF_CONTROL, 32'h2 << CTL_SEC_LO);
		bus(1'b0, OFF_ACCESS, 32'h0);
		check(rd === 32'h0 && readback_allowed === 1'b0
			&& reconfig_allowed === 1'b0, "level two");
		bus(1'b1, OFF_PHASES, 32'h12345);
		bus(1'b1, OFF_CONTROL, (32'h2 << CTL_SEC_LO) | 32'h1);
		bus(1'b0, OFF_PHASES, 32'h0);
		check(rd === 32'h000ba654, "level two write");
		wait_done(1'b0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
